// ===== verilog/pdbm_pkg.sv
// constants, mode list and shared field functions of the direct-mode bus map
// assumes one 80-bit slice per channel on each parallel bus
package pdbm_pkg;
   localparam int CH_NUM = 2;
   localparam int SLICE_W = 80;
   localparam int WORD_W = 64;
   localparam int BIT_WR_EN = 79;
   localparam int BIT_VALID = 79;
   localparam int BIT_MARK_N = 19;
   localparam int BIT_MARK_W = 39;
   localparam int BIT_RX_PDN = 16;
   localparam int BIT_TX_PDN = 17;
   localparam int BIT_TX_PUP = 18;
   localparam int BIT_FOUND = 18;
   localparam int BIT_PRBS_ERR = 35;
   localparam int BIT_PRBS_DONE = 36;
   localparam int LO64_W = 32;
   localparam int HI64_LSB = 40;
   localparam logic [1:0] ERR_HOLD = 2'h3;
   localparam logic [79:0] SLICE_RST = '0;
   localparam logic [63:0] WORD_RST = '0;

   typedef enum logic [3:0] {
      SR8, SR10, SR16, SR20, SR32, SR40, SR64,
      DR8, DR10, DR16, DR20, DR32
   } pdbm_mode_e;

   // fabric word width per mode
   function automatic logic [6:0] fab_w(pdbm_mode_e m);
      case (m)
         SR8, DR8: return 7'h08;
         SR10, DR10: return 7'h0a;
         SR16, DR16: return 7'h10;
         SR20, DR20: return 7'h14;
         SR32, DR32: return 7'h20;
         SR40: return 7'h28;
         default: return 7'h40;
      endcase
   endfunction

   function automatic logic is_dbl(pdbm_mode_e m);
      return (m == DR8) || (m == DR10) || (m == DR16) || (m == DR20) || (m == DR32);
   endfunction

   function automatic logic is_narrow(pdbm_mode_e m);
      return (m == DR8) || (m == DR10) || (m == DR16);
   endfunction

   function automatic int tx_mark_pos(pdbm_mode_e m);
      return is_narrow(m) ? BIT_MARK_N : BIT_MARK_W;
   endfunction

   // receive mark value; narrow modes use the inverted sense
   function automatic logic rx_mark(pdbm_mode_e m, logic upper);
      return is_narrow(m) ? !upper : upper;
   endfunction

   function automatic logic [63:0] mask(logic [6:0] w);
      return ~({64{1'b1}} << w);
   endfunction

   function automatic logic [63:0] pick(pdbm_mode_e m, logic [79:0] s);
      logic [63:0] d;
      d = {24'h00_0000, s[39:0]} & mask(fab_w(m));
      if (m == SR64) begin
         d = {s[HI64_LSB+LO64_W-1:HI64_LSB], s[LO64_W-1:0]};
      end
      return d;
   endfunction

   function automatic logic [79:0] place(pdbm_mode_e m, logic [63:0] d);
      logic [79:0] s;
      logic [63:0] mk;
      s = SLICE_RST;
      mk = mask(fab_w(m));
      s[39:0] = d[39:0] & mk[39:0];
      if (m == SR64) begin
         s[39:LO64_W] = '0;
         s[HI64_LSB+LO64_W-1:HI64_LSB] = d[63:LO64_W];
      end
      return s;
   endfunction

   function automatic logic [63:0] upper_half(pdbm_mode_e m, logic [63:0] d);
      return d >> fab_w(m);
   endfunction

   function automatic logic [63:0] join_halves(pdbm_mode_e m, logic [63:0] lo, logic [63:0] hi);
      return (lo & mask(fab_w(m))) | (hi << fab_w(m));
   endfunction
endpackage

// ===== verilog/pdbm_if.sv
// parallel transmit and receive buses between fabric and channel
// assumes both ends run on the same parallel clock
`timescale 1ns/1ps
interface pdbm_if;
   import pdbm_pkg::*;
   logic [CH_NUM*SLICE_W-1:0] tx_data;
   logic [CH_NUM*SLICE_W-1:0] rx_data;
   modport fab (output tx_data, input rx_data);
   modport chan (input tx_data, output rx_data);
endinterface

// ===== verilog/pdbm_err_hold.sv
// stretches each pattern-checker error to a fixed hold while done is high
// assumes err_in is a one-cycle pulse per error
`timescale 1ns/1ps
module pdbm_err_hold import pdbm_pkg::*; (
   input logic clk_in,
   input logic rst_n_in,
   input logic done_in,
   input logic err_in,
   output logic err_out
);
   logic [1:0] cnt_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_ff <= 2'h0;
      end else if (!done_in) begin
         // errors before done are not reported
         cnt_ff <= 2'h0;
      end else if (err_in) begin
         cnt_ff <= ERR_HOLD;
      end else if (cnt_ff != 2'h0) begin
         cnt_ff <= cnt_ff - 2'h1;
      end
   end

   assign err_out = (cnt_ff != 2'h0);
endmodule // pdbm_err_hold

// ===== verilog/pdbm_chan.sv
// channel end: unpacks the transmit slices, packs the receive slices
// assumes serializer-side words and status are synchronous to clk_in
// assumes mode_in only changes while rst_n_in is low
// double-rate receive words must be spaced by at least one idle cycle
// pull levels and found are levels; words and valids are one-cycle pulses
// Contract
// - each channel owns its own 80-bit slice
// - write enable and data valid on bit 79
// - 8-bit single-rate data on bits 7:0
// - 10-bit single-rate data on bits 9:0
// - 16-bit single-rate data plus pull/found sidebands
// - 20-bit single-rate data on bits 19:0
// - 32-bit single-rate, checker error 35, done 36
// - 40-bit single-rate data on bits 39:0
// - 64-bit mode splits data to 31:0, 71:40
// - 8-bit double-rate halves share bits 7:0
// - 10-bit double-rate halves share bits 9:0
// - fabric marks narrow words on bit 19
// - narrow receive mark on 39, 1=lower
// - 16-bit double-rate, sidebands in lower word
// - wide modes mark bit 39, 0=lower
// - 32-bit double-rate halves share bits 31:0
// - 20-bit double-rate halves share bits 19:0
// - report far-end receiver once detected
// - checker error three cycles, after done
`timescale 1ns/1ps
module pdbm_chan import pdbm_pkg::*; (
   input logic clk_in,
   input logic rst_n_in,
   pdbm_if.chan bus_if,
   input pdbm_mode_e mode_in,
   output logic [63:0] pma_tx_word_out [CH_NUM],
   output logic pma_tx_valid_out [CH_NUM],
   output logic rx_pulldn_out [CH_NUM],
   output logic tx_pulldn_out [CH_NUM],
   output logic tx_pullup_out [CH_NUM],
   input logic [63:0] pma_rx_word_in [CH_NUM],
   input logic pma_rx_valid_in [CH_NUM],
   input logic rx_detected_in [CH_NUM],
   input logic prbs_done_in [CH_NUM],
   input logic prbs_err_in [CH_NUM]
);
   genvar c;

   // link-detect sidebands ride every 16-bit single-rate slice
   // and only the lower slice in 16-bit double-rate
   function automatic logic side_slot(pdbm_mode_e m, logic upper);
      return (m == SR16) || ((m == DR16) && !upper);
   endfunction

   generate
      for (c = 0; c < CH_NUM; c++) begin : g_ch
         logic [79:0] ts;
         logic [63:0] tx_lo_ff;
         logic tx_have_lo_ff;
         logic tx_upper;
         logic [63:0] rx_hold_ff;
         logic rx_hi_pend_ff;
         logic [79:0] rx_slice_ff;
         logic [79:0] nxt_rx_slice;
         logic found_ff;
         logic err_held;
         logic [63:0] tx_word_ff;
         logic tx_valid_ff;
         logic rx_pdn_ff;
         logic tx_pdn_ff;
         logic tx_pup_ff;

         assign ts = bus_if.tx_data[c*SLICE_W +: SLICE_W];
         // 40-bit single-rate slices carry data on this bit; only read in double-rate
         // mark position depends on fabric width
         assign tx_upper = ts[tx_mark_pos(mode_in)];

         // outputs come from flops local to each channel
         assign pma_tx_word_out[c] = tx_word_ff;
         assign pma_tx_valid_out[c] = tx_valid_ff;
         assign rx_pulldn_out[c] = rx_pdn_ff;
         assign tx_pulldn_out[c] = tx_pdn_ff;
         assign tx_pullup_out[c] = tx_pup_ff;

         // words are taken only with write enable
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               tx_word_ff <= WORD_RST;
               tx_valid_ff <= 1'b0;
               tx_lo_ff <= WORD_RST;
               tx_have_lo_ff <= 1'b0;
            end else begin
               tx_valid_ff <= 1'b0;
               if (ts[BIT_WR_EN]) begin
                  if (!is_dbl(mode_in)) begin
                     tx_word_ff <= pick(mode_in, ts);
                     tx_valid_ff <= 1'b1;
                  end else if (!tx_upper) begin
                     // a second lower before any upper replaces the first
                     // lower word waits for its upper
                     tx_lo_ff <= pick(mode_in, ts);
                     tx_have_lo_ff <= 1'b1;
                  end else if (tx_have_lo_ff) begin
                     tx_word_ff <= join_halves(mode_in, tx_lo_ff, pick(mode_in, ts));
                     tx_valid_ff <= 1'b1;
                     tx_have_lo_ff <= 1'b0;
                  end
               end
            end
         end

         // pull controls, 16-bit modes only, lower word when double-rate
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               rx_pdn_ff <= 1'b0;
               tx_pdn_ff <= 1'b0;
               tx_pup_ff <= 1'b0;
            end else if (ts[BIT_WR_EN] && side_slot(mode_in, tx_upper)) begin
               // levels hold across upper, idle and other-mode slices
               rx_pdn_ff <= ts[BIT_RX_PDN];
               tx_pdn_ff <= ts[BIT_TX_PDN];
               tx_pup_ff <= ts[BIT_TX_PUP];
            end
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               found_ff <= 1'b0;
            end else begin
               // one flop only: the detector level is taken as synchronous
               found_ff <= rx_detected_in[c];
            end
         end

         pdbm_err_hold u_err_hold (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .done_in(prbs_done_in[c]),
            .err_in(prbs_err_in[c]),
            .err_out(err_held)
         );

         // upper half is held for the cycle after the lower
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               rx_hold_ff <= WORD_RST;
               rx_hi_pend_ff <= 1'b0;
            end else begin
               // a valid right after a valid drops the pending upper
               rx_hi_pend_ff <= is_dbl(mode_in) && pma_rx_valid_in[c];
               if (pma_rx_valid_in[c]) begin
                  rx_hold_ff <= pma_rx_word_in[c];
               end
            end
         end

         always_comb begin
            // idle slices go out all zero, sidebands aside
            nxt_rx_slice = SLICE_RST;
            if (!is_dbl(mode_in)) begin
               if (pma_rx_valid_in[c]) begin
                  nxt_rx_slice = place(mode_in, pma_rx_word_in[c]);
                  nxt_rx_slice[BIT_VALID] = 1'b1;
               end
            end else if (pma_rx_valid_in[c]) begin
               nxt_rx_slice = place(mode_in, pma_rx_word_in[c]);
               nxt_rx_slice[BIT_MARK_W] = rx_mark(mode_in, 1'b0);
               nxt_rx_slice[BIT_VALID] = 1'b1;
            end else if (rx_hi_pend_ff) begin
               nxt_rx_slice = place(mode_in, upper_half(mode_in, rx_hold_ff));
               nxt_rx_slice[BIT_MARK_W] = rx_mark(mode_in, 1'b1);
               nxt_rx_slice[BIT_VALID] = 1'b1;
            end
            if (side_slot(mode_in, !pma_rx_valid_in[c])) begin
               nxt_rx_slice[BIT_FOUND] = found_ff;
            end
            // done passes straight through; only the error is stretched
            // checker status in 32-bit single-rate
            if (mode_in == SR32) begin
               nxt_rx_slice[BIT_PRBS_ERR] = err_held;
               nxt_rx_slice[BIT_PRBS_DONE] = prbs_done_in[c];
            end
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               rx_slice_ff <= SLICE_RST;
            end else begin
               // bus is driven from flops only
               rx_slice_ff <= nxt_rx_slice;
            end
         end

         assign bus_if.rx_data[c*SLICE_W +: SLICE_W] = rx_slice_ff;
      end
   endgenerate
endmodule // pdbm_chan

// ===== verilog/pdbm_fab.sv
// fabric end: packs user words into transmit slices, unpacks receive slices
// assumes the channel end shares clk_in and the mode setting
`timescale 1ns/1ps
module pdbm_fab import pdbm_pkg::*; (
   input logic clk_in,
   input logic rst_n_in,
   pdbm_if.fab bus_if,
   input pdbm_mode_e mode_in,
   input logic [63:0] usr_tx_word_in [CH_NUM],
   input logic usr_tx_valid_in [CH_NUM],
   output logic usr_tx_ready_out [CH_NUM],
   input logic rx_pulldn_in [CH_NUM],
   input logic tx_pulldn_in [CH_NUM],
   input logic tx_pullup_in [CH_NUM],
   output logic [63:0] usr_rx_word_out [CH_NUM],
   output logic usr_rx_valid_out [CH_NUM],
   output logic rx_found_out [CH_NUM],
   output logic prbs_err_out [CH_NUM],
   output logic prbs_done_out [CH_NUM]
);
   genvar c;

   generate
      for (c = 0; c < CH_NUM; c++) begin : g_ch
         logic [79:0] tx_slice_ff;
         logic [79:0] nxt_tx_slice;
         logic tx_hi_ff;
         logic [63:0] tx_hold_ff;
         logic take;
         logic [79:0] rs;
         logic rs_lower;
         logic [63:0] rx_lo_ff;
         logic rx_have_lo_ff;

         // upper word slot stalls the user side
         assign usr_tx_ready_out[c] = !tx_hi_ff;
         assign take = usr_tx_valid_in[c] && !tx_hi_ff;

         always_comb begin
            nxt_tx_slice = SLICE_RST;
            if (take) begin
               nxt_tx_slice = place(mode_in, usr_tx_word_in[c]);
               nxt_tx_slice[BIT_WR_EN] = 1'b1;
               if (mode_in == SR16 || mode_in == DR16) begin
                  nxt_tx_slice[BIT_RX_PDN] = rx_pulldn_in[c];
                  nxt_tx_slice[BIT_TX_PDN] = tx_pulldn_in[c];
                  nxt_tx_slice[BIT_TX_PUP] = tx_pullup_in[c];
               end
            end else if (tx_hi_ff) begin
               // upper word right after the lower
               nxt_tx_slice = place(mode_in, upper_half(mode_in, tx_hold_ff));
               nxt_tx_slice[BIT_WR_EN] = 1'b1;
               nxt_tx_slice[tx_mark_pos(mode_in)] = 1'b1;
            end
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               tx_slice_ff <= SLICE_RST;
               tx_hi_ff <= 1'b0;
               tx_hold_ff <= WORD_RST;
            end else begin
               tx_slice_ff <= nxt_tx_slice;
               tx_hi_ff <= take && is_dbl(mode_in);
               if (take) begin
                  tx_hold_ff <= usr_tx_word_in[c];
               end
            end
         end

         assign bus_if.tx_data[c*SLICE_W +: SLICE_W] = tx_slice_ff;
         assign rs = bus_if.rx_data[c*SLICE_W +: SLICE_W];
         assign rs_lower = (rs[BIT_MARK_W] == rx_mark(mode_in, 1'b0));

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               usr_rx_word_out[c] <= WORD_RST;
               usr_rx_valid_out[c] <= 1'b0;
               rx_lo_ff <= WORD_RST;
               rx_have_lo_ff <= 1'b0;
            end else begin
               usr_rx_valid_out[c] <= 1'b0;
               if (rs[BIT_VALID]) begin
                  if (!is_dbl(mode_in)) begin
                     usr_rx_word_out[c] <= pick(mode_in, rs);
                     usr_rx_valid_out[c] <= 1'b1;
                  end else if (rs_lower) begin
                     rx_lo_ff <= pick(mode_in, rs);
                     rx_have_lo_ff <= 1'b1;
                  end else if (rx_have_lo_ff) begin
                     usr_rx_word_out[c] <= join_halves(mode_in, rx_lo_ff, pick(mode_in, rs));
                     usr_rx_valid_out[c] <= 1'b1;
                     rx_have_lo_ff <= 1'b0;
                  end
               end
            end
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               rx_found_out[c] <= 1'b0;
               prbs_err_out[c] <= 1'b0;
               prbs_done_out[c] <= 1'b0;
            end else begin
               if (mode_in == SR16 || (mode_in == DR16 && rs[BIT_VALID] && rs_lower)) begin
                  rx_found_out[c] <= rs[BIT_FOUND];
               end
               if (mode_in == SR32) begin
                  prbs_err_out[c] <= rs[BIT_PRBS_ERR];
                  prbs_done_out[c] <= rs[BIT_PRBS_DONE];
               end
            end
         end
      end
   endgenerate
endmodule // pdbm_fab

// ===== sim/pdbm_bus_chk_asserts.sv
// checker for the shared transmit and receive parallel buses
// assumes one clock, synchronous active-low reset and a mode held during traffic
`timescale 1ns/1ps
module pdbm_bus_chk import pdbm_pkg::*; (
   input logic clk_in,
   input logic rst_n_in,
   input pdbm_mode_e mode_in,
   input logic [CH_NUM*SLICE_W-1:0] tx_data,
   input logic [CH_NUM*SLICE_W-1:0] rx_data
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic nar, dbl, tmk, lo_rx;
   logic [39:0] sr_hi;
   assign nar = mode_in inside {DR8, DR10, DR16};
   assign dbl = nar || (mode_in inside {DR20, DR32});
   assign tmk = nar ? tx_data[19] : tx_data[39];
   // narrow modes mark the lower receive word with 1
   assign lo_rx = rx_data[39] == nar;
   // bits that must stay quiet in single-rate modes
   always_comb begin
      case (mode_in)
         SR8: sr_hi = 40'hff_ffff_ff00;
         SR10: sr_hi = 40'hff_ffff_fc00;
         SR16: sr_hi = 40'hff_fff8_0000;
         SR20: sr_hi = 40'hff_fff0_0000;
         SR32, SR64: sr_hi = 40'hff_0000_0000;
         default: sr_hi = 40'h00_0000_0000;
      endcase
   end
   property p_rst_zero;
      $rose(rst_n_in) |-> tx_data == '0 && rx_data == '0;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("bus not idle after reset");
   property p_top_zero;
      tx_data[78:72] == 7'h00 && tx_data[158:152] == 7'h00;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("unused tx bits driven");
   property p_sr_width;
      !dbl |-> (tx_data[39:0] & sr_hi) == '0 && (tx_data[119:80] & sr_hi) == '0;
   endproperty
   a_sr_width: assert property (p_sr_width) else $error("tx data outside its field");
   property p_tx_pair;
      dbl && tx_data[79] && !tmk |=> tx_data[79] && tmk;
   endproperty
   a_tx_pair: assert property (p_tx_pair) else $error("tx upper word missing");
   property p_tx_up;
      dbl && tx_data[79] && tmk |-> $past(tx_data[79]) && !$past(tmk);
   endproperty
   a_tx_up: assert property (p_tx_up) else $error("tx upper without lower");
   property p_rx_pair;
      dbl && rx_data[79] && lo_rx |=> rx_data[79] && !lo_rx;
   endproperty
   a_rx_pair: assert property (p_rx_pair) else $error("rx upper word missing");
   property p_rx_up;
      dbl && rx_data[79] && !lo_rx |-> $past(rx_data[79]) && $past(lo_rx);
   endproperty
   a_rx_up: assert property (p_rx_up) else $error("rx upper without lower");
   property p_err_hold;
      mode_in == SR32 && $rose(rx_data[35]) |-> rx_data[35] [*3];
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("checker error too short");
   property p_err_done;
      mode_in == SR32 && $rose(rx_data[35]) |-> rx_data[36];
   endproperty
   a_err_done: assert property (p_err_done) else $error("checker error before done");
   c_tx_pair: cover property (dbl && tx_data[79] && tmk);
   c_rx_pair: cover property (dbl && rx_data[79] && !lo_rx);
   c_err: cover property ($rose(rx_data[35]));
endmodule // pdbm_bus_chk

// ===== sim/tb.sv
// end-to-end bench: fabric end and channel end joined by the bus interface
// assumes every mode is entered under its own reset, 250 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
   import pdbm_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   pdbm_mode_e mode = SR8;
   int failures = 0;
   int tests_run = 0;
   int seed = 17933;
   logic [63:0] ut_w [CH_NUM], pt_w [CH_NUM], ur_w [CH_NUM], pr_w [CH_NUM], exp_w [CH_NUM];
   logic ut_v [CH_NUM], ut_r [CH_NUM], rpd_i [CH_NUM], tpd_i [CH_NUM], tpu_i [CH_NUM];
   logic rpd_o [CH_NUM], tpd_o [CH_NUM], tpu_o [CH_NUM], pt_v [CH_NUM], ur_v [CH_NUM];
   logic fnd [CH_NUM], pe_o [CH_NUM], pd_o [CH_NUM], pr_v [CH_NUM], det [CH_NUM];
   logic pd_i [CH_NUM], pe_i [CH_NUM];
   always #2 clk_in = ~clk_in;
   pdbm_if i_pdbm_if();
   pdbm_fab i_pdbm_fab(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_if(i_pdbm_if.fab), .mode_in(mode),
      .usr_tx_word_in(ut_w), .usr_tx_valid_in(ut_v), .usr_tx_ready_out(ut_r), .rx_pulldn_in(rpd_i),
      .tx_pulldn_in(tpd_i), .tx_pullup_in(tpu_i), .usr_rx_word_out(ur_w), .usr_rx_valid_out(ur_v),
      .rx_found_out(fnd), .prbs_err_out(pe_o), .prbs_done_out(pd_o));
   pdbm_chan i_pdbm_chan(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_if(i_pdbm_if.chan), .mode_in(mode),
      .pma_tx_word_out(pt_w), .pma_tx_valid_out(pt_v), .rx_pulldn_out(rpd_o), .tx_pulldn_out(tpd_o),
      .tx_pullup_out(tpu_o), .pma_rx_word_in(pr_w), .pma_rx_valid_in(pr_v), .rx_detected_in(det),
      .prbs_done_in(pd_i), .prbs_err_in(pe_i));
   pdbm_bus_chk i_pdbm_bus_chk(.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
      .tx_data(i_pdbm_if.tx_data), .rx_data(i_pdbm_if.rx_data));
   function automatic logic is_dr(pdbm_mode_e m);
      return m inside {DR8, DR10, DR16, DR20, DR32};
   endfunction
   // a double-rate word carries two fabric widths
   function automatic logic [63:0] wmask(pdbm_mode_e m);
      int w;
      case (m)
         SR8, DR8: w = 8;
         SR10, DR10: w = 10;
         SR16, DR16: w = 16;
         SR20, DR20: w = 20;
         SR32, DR32: w = 32;
         SR40: w = 40;
         default: w = 64;
      endcase
      if (is_dr(m)) w = 2 * w;
      return (w == 64) ? {64{1'b1}} : ~({64{1'b1}} << w);
   endfunction
   // ones gives the hand-written all-ones corner: data and every sideband high
   task automatic tx_one(bit ones);
      int n;
      logic [2:0] pl [CH_NUM];
      @(negedge clk_in);
      for (int c = 0; c < CH_NUM; c++) begin
         ut_w[c] = ones ? {64{1'b1}} : {$random(seed), $random(seed)};
         exp_w[c] = ut_w[c] & wmask(mode);
         pl[c] = ones ? 3'h7 : 3'($random(seed));
         {tpu_i[c], tpd_i[c], rpd_i[c]} = pl[c];
      end
      ut_v = '{default: 1'b1};
      n = 0;
      while (ut_r[0] !== 1'b1 && n < 8) begin
         @(negedge clk_in);
         n++;
      end
      @(negedge clk_in);
      // upper slot closes the user port for one cycle
      for (int c = 0; c < CH_NUM; c++) begin
         `CHK("tx ready", !is_dr(mode), ut_r[c])
      end
      ut_v = '{default: 1'b0};
      n = 0;
      while (pt_v[0] !== 1'b1 && n < 8) begin
         @(negedge clk_in);
         n++;
      end
      for (int c = 0; c < CH_NUM; c++) begin
         `CHK("tx valid", 1'b1, pt_v[c])
         `CHK("tx word", exp_w[c], pt_w[c])
         if (mode inside {SR16, DR16}) `CHK("pull bits", pl[c], {tpu_o[c], tpd_o[c], rpd_o[c]})
      end
   endtask
   task automatic rx_one(bit ones);
      int n;
      @(negedge clk_in);
      for (int c = 0; c < CH_NUM; c++) begin
         pr_w[c] = ones ? {64{1'b1}} : {$random(seed), $random(seed)};
         exp_w[c] = pr_w[c] & wmask(mode);
      end
      pr_v = '{default: 1'b1};
      @(negedge clk_in);
      pr_v = '{default: 1'b0};
      n = 0;
      while (ur_v[0] !== 1'b1 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      for (int c = 0; c < CH_NUM; c++) begin
         `CHK("rx valid", 1'b1, ur_v[c])
         `CHK("rx word", exp_w[c], ur_w[c])
      end
   endtask
   // errors only count while done is up
   task automatic prbs_chk(logic dn, int exp_n);
      int n;
      pd_i = '{default: dn};
      repeat (4) @(negedge clk_in);
      pe_i = '{default: 1'b1};
      @(negedge clk_in);
      pe_i = '{default: 1'b0};
      n = 0;
      repeat (10) begin
         @(negedge clk_in);
         for (int c = 0; c < CH_NUM; c++) begin
            if (pe_o[c] !== 1'b0) n++;
         end
      end
      `CHK("err cycles", exp_n * CH_NUM, n)
      for (int c = 0; c < CH_NUM; c++) begin
         `CHK("done", dn, pd_o[c])
      end
   endtask
   task automatic print_verdict();
      $display("counts: %0d checks, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      ut_w = '{default: '0};
      pr_w = '{default: '0};
      ut_v = '{default: 1'b0};
      pr_v = '{default: 1'b0};
      rpd_i = '{default: 1'b0};
      tpd_i = '{default: 1'b0};
      tpu_i = '{default: 1'b0};
      det = '{default: 1'b0};
      pd_i = '{default: 1'b0};
      pe_i = '{default: 1'b0};
      for (int m = 0; m < 12; m++) begin
         mode = pdbm_mode_e'(m);
         rst_n_in = 1'b0;
         repeat (10) @(negedge clk_in);
         rst_n_in = 1'b1;
         det[0] = 1'($random(seed));
         det[1] = ~det[0];
         repeat (6) tx_one(1'b0);
         tx_one(1'b1);
         repeat (6) rx_one(1'b0);
         rx_one(1'b1);
         for (int c = 0; c < CH_NUM; c++) begin
            if (mode inside {SR16, DR16}) `CHK("found", det[c], fnd[c])
         end
         if (mode == SR32) begin
            prbs_chk(1'b1, 3);
            prbs_chk(1'b0, 0);
         end
         $display("test mode %0d done", m);
      end
      print_verdict();
   end
   // the run needs under a thousand cycles; this limit lies far beyond
   initial begin
      #100000;
      failures++;
      print_verdict();
   end
endmodule // tb
